//--- gated_event_timer_pkg.sv
/*
  Constants, register map and field layout of the gated event timer channel.
  Assumes a 32-bit register port with byte addresses and one channel per instance.
*/
package gated_event_timer_pkg;

  // Counter geometry.
  localparam int unsigned CNT_W         = 16;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;

  // Register byte offsets.
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_RELOAD    = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam logic [7:0]  OFS_PRESCALE  = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;

  // Control register fields.
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_BIT  = 1;
  localparam int unsigned CTRL_DIR_BIT   = 2;
  localparam int unsigned CTRL_RLSEL_BIT = 3;
  localparam int unsigned CTRL_PULSE_BIT = 4;
  localparam int unsigned CTRL_SRST_BIT  = 5;
  localparam int unsigned CTRL_EDGE_LSB  = 8;
  localparam int unsigned CTRL_EDGE_MSB  = 10;

  // Status register fields.
  localparam int unsigned STAT_WRAP_BIT  = 0;
  localparam int unsigned STAT_PIN_BIT   = 1;
  localparam int unsigned STAT_OUT_BIT   = 2;
  localparam int unsigned STAT_RUN_BIT   = 3;

  // Reset values.
  localparam logic [15:0] RELOAD_RST    = 16'h0000;
  localparam logic [15:0] PRESCALE_RST  = 16'h0000;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  typedef enum logic {
    MODE_TIMER = 1'b0,
    MODE_EVENT = 1'b1
  } mode_t;

  typedef enum logic [2:0] {
    EDGE_PIN_RISE  = 3'b000,
    EDGE_PIN_FALL  = 3'b001,
    EDGE_PIN_BOTH  = 3'b010,
    EDGE_OVF_RISE  = 3'b011,
    EDGE_OVF_FALL  = 3'b100,
    EDGE_OVF_BOTH  = 3'b101
  } edge_sel_t;

endpackage : gated_event_timer_pkg

//--- event_sense_if.sv
/*
  Carries the conditioned timer input pin and previous-channel overflow.
  Assumes both ends run on the timer clock.
*/
`timescale 1ns/100ps
interface event_sense_if;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic ovf_rise;
  logic ovf_fall;

  modport src (output pin_level, pin_rise, pin_fall, ovf_rise, ovf_fall);
  modport dst (input  pin_level, pin_rise, pin_fall, ovf_rise, ovf_fall);
endinterface : event_sense_if

//--- event_sense.sv
/*
  Synchroniser and edge detector for the timer input pin and overflow input.
  Assumes asynchronous inputs and a single timer clock.
*/
`timescale 1ns/100ps
module event_sense
  import gated_event_timer_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_i,
  input  wire logic    nrst_i,
  // Raw inputs, bit 0 pin, bit 1 overflow
  input  wire logic    timer_input_pin_i,
  input  wire logic    prev_overflow_i,
  // Conditioned outputs
  event_sense_if.src   sense
);

  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic [1:0] last_reg;
  logic [1:0] last_next;

  always_comb begin
    meta_next = {prev_overflow_i, timer_input_pin_i};
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
      last_reg <= 2'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign sense.pin_level = sync_reg[0];
  assign sense.pin_rise  = sync_reg[0] & ~last_reg[0];
  assign sense.pin_fall  = ~sync_reg[0] & last_reg[0];
  assign sense.ovf_rise  = sync_reg[1] & ~last_reg[1];
  assign sense.ovf_fall  = ~sync_reg[1] & last_reg[1];

endmodule : event_sense

//--- gated_event_timer.sv
/*
  One 16-bit timer channel with timer mode (gated down counter with pulse
  output) and event mode (up/down event counter), behind a simple register port.
  Assumes a single 200 MHz clock, an asynchronous active-low reset, and a
  register master that never issues read and write strobes together.
*/
`timescale 1ns/100ps

// Overview of operation
// - Timer mode with gate on halts while input pin low, counts while high.
// - Direction select bit enables the input pin gate in timer mode.
// - Timer mode pulse output toggles the output pin on each underflow.
// - Output pin is driven low whenever the enable bit is clear.
// - Event mode counts input pin edges or previous channel overflow edges.
// - Event mode direction select bit chooses up or down counting.
// - Six edge choices: pin rise, fall, both; overflow rise, fall, both.
// - Event underflow loads reload value if reload select set, else FFFFh.
// - Event overflow loads reload value if reload select set, else 0000h.
// - Event counting runs from enable set until firmware clears enable.
// - Event mode raises an interrupt request on each overflow and underflow.
// - Event mode pulse output toggles output pin on every wrap.
// - Live counter value is readable through the count register.
// - Soft reset copies the reload register into the counter at once, or loads 0000h for event up counting.
// - Reload write without soft reset takes effect at the next wrap if reload select set.
// - Re-enabling without reset resumes from the held counter value.
// - After soft reset, down counting starts from reload, up from 0000h.
// - Timer mode counts down; underflow reloads or wraps to FFFFh.
// - Timer mode raises an interrupt request on each underflow.
module gated_event_timer
  import gated_event_timer_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // Timer pins
  input  wire logic              timer_input_pin_i,
  input  wire logic              prev_overflow_i,
  output logic                   timer_output_pin_o,
  // Events to the system and next channel
  output logic                   timer_irq_o,
  output logic                   timer_wrap_o
);

  event_sense_if sense ();

  event_sense u_sense (
    .clk_i             (clk_i),
    .nrst_i            (nrst_i),
    .timer_input_pin_i (timer_input_pin_i),
    .prev_overflow_i   (prev_overflow_i),
    .sense             (sense.src)
  );

  // Control state.
  logic                 enable_reg;
  logic                 enable_next;
  mode_t                mode_reg;
  mode_t                mode_next;
  logic                 count_direction_select_reg;
  logic                 count_direction_select_next;
  logic                 reload_on_wrap_select_reg;
  logic                 reload_on_wrap_select_next;
  logic                 pulse_en_reg;
  logic                 pulse_en_next;
  edge_sel_t            edge_sel_reg;
  edge_sel_t            edge_sel_next;
  logic [CNT_W-1:0]     reload_reg;
  logic [CNT_W-1:0]     reload_next;
  logic [CNT_W-1:0]     prescale_reg;
  logic [CNT_W-1:0]     prescale_next;

  // Counting state.
  logic [CNT_W-1:0]     count_reg;
  logic [CNT_W-1:0]     count_next;
  logic [CNT_W-1:0]     presc_cnt_reg;
  logic [CNT_W-1:0]     presc_cnt_next;
  logic                 timer_pulse_out_reg;
  logic                 timer_pulse_out_next;
  logic                 irq_reg;
  logic                 irq_next;
  logic                 wrap_out_reg;
  logic                 wrap_out_next;
  logic                 wrap_flag_reg;
  logic                 wrap_flag_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;

  // Decoded strobes and conditions.
  logic                 wr_ctrl;
  logic                 wr_reload;
  logic                 wr_prescale;
  logic                 wr_status;
  logic                 soft_reset;
  logic                 gate_open;
  logic                 timer_run;
  logic                 tick;
  logic                 event_hit;
  logic                 advance;
  logic                 counting_up;
  logic                 at_limit;
  logic                 wrap;
  logic [CNT_W-1:0]     wrap_value;

  // Register write decode. Addresses are compared in full, so a write to an
  // unmapped offset changes nothing.
  always_comb begin
    wr_ctrl     = reg_wr_i && (reg_addr_i == OFS_CTRL);
    wr_reload   = reg_wr_i && (reg_addr_i == OFS_RELOAD);
    wr_prescale = reg_wr_i && (reg_addr_i == OFS_PRESCALE);
    wr_status   = reg_wr_i && (reg_addr_i == OFS_STATUS);
    soft_reset  = wr_ctrl && reg_wdata_i[CTRL_SRST_BIT];
  end

  // Control registers take their new values on a control write, reload and prescale on their own writes.
  always_comb begin
    enable_next                 = enable_reg;
    mode_next                   = mode_reg;
    count_direction_select_next = count_direction_select_reg;
    reload_on_wrap_select_next  = reload_on_wrap_select_reg;
    pulse_en_next               = pulse_en_reg;
    edge_sel_next               = edge_sel_reg;
    reload_next                 = reload_reg;
    prescale_next               = prescale_reg;
    if (wr_ctrl) begin
      enable_next                 = reg_wdata_i[CTRL_EN_BIT];
      mode_next                   = mode_t'(reg_wdata_i[CTRL_MODE_BIT]);
      count_direction_select_next = reg_wdata_i[CTRL_DIR_BIT];
      reload_on_wrap_select_next  = reg_wdata_i[CTRL_RLSEL_BIT];
      pulse_en_next               = reg_wdata_i[CTRL_PULSE_BIT];
      edge_sel_next               = edge_sel_t'(reg_wdata_i[CTRL_EDGE_MSB:CTRL_EDGE_LSB]);
    end
    if (wr_reload) begin
      reload_next = reg_wdata_i[CNT_W-1:0];
    end
    if (wr_prescale) begin
      prescale_next = reg_wdata_i[CNT_W-1:0];
    end
  end

  // Timer tick: one tick every prescale+1 clocks while the timer may run.
  always_comb begin
    gate_open = !count_direction_select_reg || sense.pin_level;
    timer_run = enable_reg && (mode_reg == MODE_TIMER) && gate_open;
    // A prescale lowered below the running divider must not stall the tick
    // until the divider rolls round its whole range, so the limit is inclusive.
    tick      = timer_run && (presc_cnt_reg >= prescale_reg);
    presc_cnt_next = presc_cnt_reg;
    if (soft_reset) begin
      presc_cnt_next = COUNT_ZERO;
    end else if (timer_run) begin
      presc_cnt_next = tick ? COUNT_ZERO : presc_cnt_reg + COUNT_ONE;
    end
  end

  // Event selection. Codes 6 and 7 select no source and never count.
  always_comb begin
    unique case (edge_sel_reg)
      EDGE_PIN_RISE: event_hit = sense.pin_rise;
      EDGE_PIN_FALL: event_hit = sense.pin_fall;
      EDGE_PIN_BOTH: event_hit = sense.pin_rise | sense.pin_fall;
      EDGE_OVF_RISE: event_hit = sense.ovf_rise;
      EDGE_OVF_FALL: event_hit = sense.ovf_fall;
      EDGE_OVF_BOTH: event_hit = sense.ovf_rise | sense.ovf_fall;
      default:       event_hit = 1'b0;
    endcase
  end

  // Counter step, wrap detection and soft reset load.
  always_comb begin
    // enable alone starts and stops event counting
    advance = enable_reg &&
              (((mode_reg == MODE_TIMER) && tick) ||
               ((mode_reg == MODE_EVENT) && event_hit));
    counting_up = (mode_reg == MODE_EVENT) && count_direction_select_reg;
    at_limit    = counting_up ? (count_reg == COUNT_MAX) : (count_reg == COUNT_ZERO);
    wrap        = advance && at_limit;
    if (reload_on_wrap_select_reg) begin
      wrap_value = reload_reg;
    end else begin
      wrap_value = counting_up ? COUNT_ZERO : COUNT_MAX;
    end
    count_next = count_reg;
    // Soft reset reads the mode and direction being written, so one write both
    // selects up counting and starts it from zero.
    if (soft_reset) begin
      if ((mode_t'(reg_wdata_i[CTRL_MODE_BIT]) == MODE_EVENT) &&
          reg_wdata_i[CTRL_DIR_BIT]) begin
        count_next = COUNT_ZERO;
      end else begin
        count_next = reload_reg;
      end
    end else if (wrap) begin
      count_next = wrap_value;
    end else if (advance) begin
      count_next = counting_up ? count_reg + COUNT_ONE : count_reg - COUNT_ONE;
    end
  end

  // Pulse output, interrupt request and wrap reporting.
  always_comb begin
    timer_pulse_out_next = timer_pulse_out_reg;
    if (!enable_reg) begin
      timer_pulse_out_next = 1'b0;
    end else if (wrap && pulse_en_reg) begin
      timer_pulse_out_next = !timer_pulse_out_reg;
    end
    irq_next      = wrap;
    wrap_out_next = wrap;
    // Request and wrap out share one condition but keep a flop each, so every
    // output port comes straight from its own register.
    // A wrap in the same cycle as the clear keeps the flag set.
    wrap_flag_next = wrap ||
                     (wrap_flag_reg && !(wr_status && reg_wdata_i[STAT_WRAP_BIT]));
  end

  // Read data stands only in the cycle after the read strobe.
  always_comb begin
    rdata_next = RDATA_ZERO;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CTRL: begin
          rdata_next[CTRL_EN_BIT]                 = enable_reg;
          rdata_next[CTRL_MODE_BIT]               = mode_reg;
          rdata_next[CTRL_DIR_BIT]                = count_direction_select_reg;
          rdata_next[CTRL_RLSEL_BIT]              = reload_on_wrap_select_reg;
          rdata_next[CTRL_PULSE_BIT]              = pulse_en_reg;
          rdata_next[CTRL_EDGE_MSB:CTRL_EDGE_LSB] = edge_sel_reg;
        end
        OFS_RELOAD: begin
          rdata_next[CNT_W-1:0] = reload_reg;
        end
        OFS_COUNT: begin
          rdata_next[CNT_W-1:0] = count_reg;
        end
        OFS_PRESCALE: begin
          rdata_next[CNT_W-1:0] = prescale_reg;
        end
        OFS_STATUS: begin
          rdata_next[STAT_WRAP_BIT] = wrap_flag_reg;
          rdata_next[STAT_PIN_BIT]  = sense.pin_level;
          rdata_next[STAT_OUT_BIT]  = timer_pulse_out_reg;
          rdata_next[STAT_RUN_BIT]  = timer_run;
        end
        default: begin
          rdata_next = RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_reg                 <= 1'b0;
      mode_reg                   <= MODE_TIMER;
      count_direction_select_reg <= 1'b0;
      reload_on_wrap_select_reg  <= 1'b0;
      pulse_en_reg               <= 1'b0;
      edge_sel_reg               <= EDGE_PIN_RISE;
      reload_reg                 <= RELOAD_RST;
      prescale_reg               <= PRESCALE_RST;
    end else begin
      enable_reg                 <= enable_next;
      mode_reg                   <= mode_next;
      count_direction_select_reg <= count_direction_select_next;
      reload_on_wrap_select_reg  <= reload_on_wrap_select_next;
      pulse_en_reg               <= pulse_en_next;
      edge_sel_reg               <= edge_sel_next;
      reload_reg                 <= reload_next;
      prescale_reg               <= prescale_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_cnt_reg <= COUNT_ZERO;
    end else begin
      presc_cnt_reg <= presc_cnt_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= COUNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_pulse_out_reg <= 1'b0;
      irq_reg             <= 1'b0;
      wrap_out_reg        <= 1'b0;
      wrap_flag_reg       <= 1'b0;
    end else begin
      timer_pulse_out_reg <= timer_pulse_out_next;
      irq_reg             <= irq_next;
      wrap_out_reg        <= wrap_out_next;
      wrap_flag_reg       <= wrap_flag_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= RDATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o        = rdata_reg;
  assign timer_output_pin_o = timer_pulse_out_reg;
  assign timer_irq_o        = irq_reg;
  assign timer_wrap_o       = wrap_out_reg;

endmodule : gated_event_timer

//--- gated_event_timer_monitor.sv
/* Checker of the timer channel behaviour at its ports.
   Assumes it is bound to gated_event_timer and sees only its ports. */
`timescale 1ns/100ps
module gated_event_timer_monitor
  import gated_event_timer_pkg::*;
(
  // Clock, reset and register port
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  // Pins and events
  input wire logic              timer_input_pin_i,
  input wire logic              prev_overflow_i,
  input wire logic              timer_output_pin_o,
  input wire logic              timer_irq_o,
  input wire logic              timer_wrap_o
);
  logic       en_q;
  logic       gate_q;
  logic       pulse_q;
  logic [3:0] low_cnt;

  // Shadow control bits, taken at the same edge as the write.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q    <= 1'b0;
      gate_q  <= 1'b0;
      pulse_q <= 1'b0;
      low_cnt <= 4'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
        en_q    <= reg_wdata_i[CTRL_EN_BIT];
        gate_q  <= reg_wdata_i[CTRL_DIR_BIT] && !reg_wdata_i[CTRL_MODE_BIT];
        pulse_q <= reg_wdata_i[CTRL_PULSE_BIT];
      end
      if (timer_input_pin_i)
        low_cnt <= 4'h0;
      else if (low_cnt != 4'hF)
        low_cnt <= low_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_wrap_pulse;
    timer_irq_o && $past(en_q) && $past(pulse_q);
  endsequence
  sequence s_bad_read;
    reg_rd_i && reg_addr_i == 8'h14;
  endsequence

  a_irq_wrap_pair: assert property (timer_irq_o == timer_wrap_o)
    else $error("irq and wrap pulses differ");
  a_out_toggle: assert property (s_wrap_pulse |-> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output pin did not toggle on wrap");
  a_out_hold: assert property ($past(en_q) && en_q && !timer_irq_o |-> $stable(timer_output_pin_o))
    else $error("output pin moved without wrap");
  a_no_pulse: assert property ($past(en_q) && timer_irq_o && !$past(pulse_q) |-> $stable(timer_output_pin_o))
    else $error("output pin moved with pulse off");
  a_out_clear: assert property (!en_q |=> !timer_output_pin_o)
    else $error("output pin high while disabled");
  a_irq_enabled: assert property (timer_irq_o |-> $past(en_q))
    else $error("wrap while disabled");
  a_gate_hold: assert property ($past(en_q) && $past(gate_q) && low_cnt > 4'h5 |-> !timer_irq_o)
    else $error("gated timer wrapped");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == RDATA_ZERO)
    else $error("read data outside read cycle");
  a_bad_read: assert property (s_bad_read |=> reg_rdata_o == RDATA_ZERO)
    else $error("unmapped read not zero");
endmodule : gated_event_timer_monitor

bind gated_event_timer gated_event_timer_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .timer_input_pin_i(timer_input_pin_i),
  .prev_overflow_i(prev_overflow_i), .timer_output_pin_o(timer_output_pin_o),
  .timer_irq_o(timer_irq_o), .timer_wrap_o(timer_wrap_o));

//--- event_source.sv
/* Model of the outside source of the gate pin and the overflow input.
   Assumes one caller at a time and the timer clock as reference. */
`timescale 1ns/100ps
module event_source (
  // Clock
  input  wire logic clk_i,
  // Levels towards the timer channel
  output logic      timer_input_pin_o,
  output logic      prev_overflow_o
);
  initial begin
    timer_input_pin_o = 1'b0;
    prev_overflow_o   = 1'b0;
  end

  // hold each level.
  // Hold of two is the shortest legal level, so slow and prompt sources both occur.
  task automatic drive(input logic pin, input logic ovf, input int hold);
    @(posedge clk_i);
    timer_input_pin_o <= pin;
    prev_overflow_o   <= ovf;
    repeat (hold) @(posedge clk_i);
  endtask : drive
endmodule : event_source

//--- tb.sv
/* Self-checking bench of the timer channel through its register port.
   Assumes the checker binds itself and the source model drives the pins. */
`timescale 1ns/100ps
module tb;
  import gated_event_timer_pkg::*;
  logic              clk_i       = 1'b0;
  logic              nrst_i      = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i  = 8'h00;
  logic [31:0]       reg_wdata_i = 32'h0000_0000;
  logic              reg_wr_i    = 1'b0;
  logic              reg_rd_i    = 1'b0;
  logic [31:0]       reg_rdata_o;
  logic              pin;
  logic              ovf;
  logic              out_pin;
  logic              irq;
  logic [31:0]       d;
  logic [31:0]       d2;
  int                error_cnt   = 0;
  int                n_tests     = 0;
  int                irq_cnt     = 0;
  int                cyc;

  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (irq === 1'b1) irq_cnt++;

  gated_event_timer uut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .timer_input_pin_i(pin), .prev_overflow_i(ovf),
    .timer_output_pin_o(out_pin), .timer_irq_o(irq), .timer_wrap_o());
  event_source src (.clk_i(clk_i), .timer_input_pin_o(pin), .prev_overflow_o(ovf));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 200);
    if (n >= 200) chk("irq wait", 32'h0, 32'h1);
  endtask : wait_irq

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    #50000;
    error_cnt++;
    $display("[FAIL] watchdog expected end seen hang");
    finish_test;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(OFS_COUNT, d);  chk("count reset", d, 32'h0000_0000);
    wr(8'h14, 32'h0000_FFFF);
    rd(8'h14, d);      chk("unmapped", d, 32'h0000_0000);
    $display("test registers done");
    // Timer mode with reload and pulse output.
    wr(OFS_RELOAD, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0020);
    rd(OFS_COUNT, d);  chk("soft reset load", d, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0019);
    wait_irq(cyc);     chk("pulse high", {31'h0, out_pin}, 32'h1);
    wait_irq(cyc);     chk("reload period", cyc, 32'h4);
    chk("pulse low", {31'h0, out_pin}, 32'h0);
    wr(OFS_PRESCALE, 32'h0000_0001);
    wait_irq(cyc);
    wait_irq(cyc);     chk("prescale period", cyc, 32'h8);
    wr(OFS_PRESCALE, 32'h0000_0000);
    wait_irq(cyc);
    wr(OFS_CTRL, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    #1 chk("out cleared", {31'h0, out_pin}, 32'h0);
    $display("test reload done");
    // Free running wrap, then stop and resume.
    wr(OFS_RELOAD, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0020);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_irq(cyc);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_COUNT, d);  chk("free wrap", {d[31:8], 8'h00}, 32'h0000_FF00);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_COUNT, d2); chk("resume", d2, d - 32'h2);
    $display("test free run done");
    // Gate closed by a low pin, then opened.
    wr(OFS_RELOAD, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0020);
    wr(OFS_CTRL, 32'h0000_000D);
    repeat (20) @(posedge clk_i);
    rd(OFS_COUNT, d);  chk("gate closed", d, 32'h0000_0004);
    src.drive(1'b1, 1'b0, 2);
    wait_irq(cyc);
    src.drive(1'b0, 1'b0, 5);
    rd(OFS_COUNT, d);
    repeat (8) @(posedge clk_i);
    rd(OFS_COUNT, d2); chk("gate halt", d2, d);
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test gate done");
    // Every edge choice, counting up from a soft reset.
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CTRL, 32'h0000_0027 | (32'(k) << 8));
      src.drive(1'b1, 1'b0, 2);
      src.drive(1'b0, 1'b0, 2);
      src.drive(1'b0, 1'b1, 2);
      src.drive(1'b0, 1'b0, 5);
      rd(OFS_COUNT, d);
      d2 = (k > 5) ? 32'h0 : ((k == 2 || k == 5) ? 32'h2 : 32'h1);
      chk("edge count", d, d2);
    end
    $display("test edges done");
    // Event wraps both ways with pulse output.
    wr(OFS_RELOAD, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0233);
    rd(OFS_COUNT, d);  chk("down start", d, 32'h0000_0001);
    cyc = irq_cnt;
    src.drive(1'b1, 1'b0, 2);
    src.drive(1'b0, 1'b0, 5);
    rd(OFS_COUNT, d);  chk("under wrap", d, 32'h0000_FFFF);
    wr(OFS_CTRL, 32'h0000_0217);
    src.drive(1'b1, 1'b0, 5);
    rd(OFS_COUNT, d);  chk("over wrap", d, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_0005);
    rd(OFS_COUNT, d);  chk("reload no load", d, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_021B);
    src.drive(1'b0, 1'b0, 5);
    rd(OFS_COUNT, d);  chk("under reload", d, 32'h0000_0005);
    chk("event irqs", irq_cnt - cyc, 32'h3);
    chk("event pulse", {31'h0, out_pin}, 32'h1);
    rd(OFS_STATUS, d); chk("status", d, 32'h0000_0005);
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, d); chk("status clear", d, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test event wraps done");
    finish_test;
  end
endmodule : tb
